// ---- common/map_video_pkg.sv ----
package map_video_pkg;
// ****************************************************************
// Summary of operation
// - Five bit-plane memories: four map planes give 16 levels, fifth holds overlay.
// - Each memory sits on the input bus or display bus, chosen by CPU.
// - Host writes control words, then raises mode request; CPU reads and acts.
// - Timing drives display addresses with sync; 512-pixel mode adds field index.
// - Memory selection and display timing run from the display clock.
// - Memories feed the display bus one 32-bit word each into own serialiser.
// - Serialisers give a five-line serial bus to monitor selectors and mapper.
// - Per-monitor digital display register picks memories shown as inset data.
// - Each digital display register also drives that monitor's text enable line.
// - Map display register gives four lines selecting the mapper function.
// - Map display register drives two map enables, one per monitor.
// - Mapper offers 16-level and 8-level maps; 8-level drops plane in memory 2.
// - Sliding mode shows any eight consecutive of 16 levels as 8-level map.
// - Mapped result leaves on four lines weighted 1, 2, 4 and 8.
// - Map output gated by blanking and the show-map status bit.
// - Status register also holds text activate and inset white/black select.
// - External video register gives four source selects for each monitor.
// - Display bus serves only CPU and map generator, no host, no clock making.
// - Text page memory holds 25 rows of 80 characters.
// - In text input mode the CPU writes characters at its chosen address.
// - In text display mode CPU writes are shut out; timing reads the page.
// - Bus-select register puts chosen memories on input bus, rest on display bus.
// ****************************************************************

localparam int NUM_MEMS = 5;
localparam int WORD_W = 32;
localparam int MAP_PLANES = 4;
localparam int TEXT_ROWS = 25;
localparam int TEXT_COLS = 80;
localparam int PAGE_DEPTH = TEXT_ROWS * TEXT_COLS;
localparam int ADR_W = 14;

// register byte offsets
localparam logic [13:0] OFF_BUS_SEL = 14'h0000;
localparam logic [13:0] OFF_MON1_DIG = 14'h0004;
localparam logic [13:0] OFF_MON2_DIG = 14'h0008;
localparam logic [13:0] OFF_MAP_DISP = 14'h000c;
localparam logic [13:0] OFF_DISP_STAT = 14'h0010;
localparam logic [13:0] OFF_EXT_VID = 14'h0014;
localparam logic [13:0] OFF_MODE_STAT = 14'h0018;
localparam logic [13:0] OFF_TIMING = 14'h001c;
localparam logic [13:0] OFF_PAGE_BASE = 14'h2000;

// field positions
localparam int DIG_TEXT_BIT = 5;
localparam int MAP_MON1_BIT = 4;
localparam int MAP_MON2_BIT = 5;
localparam int STAT_SHOW_MAP = 0;
localparam int STAT_TEXT_ACT = 1;
localparam int STAT_INSET_WHITE = 2;
localparam int MODE_FLAG_BIT = 0;
localparam int MODE_LEVEL_BIT = 1;
localparam int TIMING_HIRES_BIT = 0;

// mapper function codes; 0..8 pick the sliding base level
localparam logic [3:0] MAP_FULL = 4'hf;
localparam logic [3:0] MAP_EIGHT = 4'he;
localparam logic [3:0] SLIDE_MAX = 4'h8;
localparam logic [3:0] SLIDE_SPAN = 4'h7;
localparam logic [3:0] SLIDE_TOP = 4'he;

typedef struct packed {
    logic [4:0] bus_sel;
    logic [5:0] mon1_dig;
    logic [5:0] mon2_dig;
    logic [5:0] map_disp;
    logic [2:0] disp_stat;
    logic [7:0] ext_vid;
    logic hires;
} ctrl_s;

localparam ctrl_s CTRL_RESET = '0;

endpackage : map_video_pkg

// ---- design/map_video_display_pipeline.sv ----
`timescale 1ns/1ps
module map_video_display_pipeline #(
    parameter int H_TOTAL = 640,
    parameter int H_ACTIVE = 512,
    parameter int V_TOTAL = 263,
    parameter int V_ACTIVE = 240,
    parameter int CHAR_H = 10
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // host request pin
    input wire logic mode_request_i,
    // display memories
    output logic [4:0] bus_select_o,
    output logic [4:0] mem_read_o,
    output logic [15:0] display_addr_bus_o,
    input wire logic [31:0] display_data_bus_i,
    // mixer side
    output logic mon_one_inset_data_o,
    output logic mon_two_inset_data_o,
    output logic mon_one_text_enable_o,
    output logic mon_two_text_enable_o,
    output logic mon_one_map_enable_o,
    output logic mon_two_map_enable_o,
    output logic [3:0] mapped_shade_out_o,
    output logic show_map_o,
    output logic text_activate_o,
    output logic inset_white_select_o,
    output logic [3:0] mon_one_ext_select_o,
    output logic [3:0] mon_two_ext_select_o,
    output logic blank_o,
    output logic field_o,
    output logic [7:0] text_char_o
);

    // ****************************************************************
    // register bus
    // ****************************************************************
    map_video_pkg::ctrl_s ctrl_q;
    map_video_pkg::ctrl_s ctrl_d;
    logic ack_q;
    logic [31:0] rdat_q;
    logic mreq_s1_q, mreq_s2_q, mreq_s3_q;
    logic mflag_q;

    function automatic logic hit(input logic [13:0] adr, input logic [13:0] off);
        hit = adr[13:2] == off[13:2];
    endfunction : hit

    wire req = wb_cyc_i & wb_stb_i;
    // a write lands on the edge that ack is seen, as the master expects
    wire wr_fire = req & ack_q & wb_we_i & wb_sel_i[0];
    wire [7:0] wb_byte = wb_dat_i[7:0];
    wire [10:0] page_idx = wb_adr_i[12:2];
    wire page_hit = wb_adr_i[13] & (page_idx < 11'(map_video_pkg::PAGE_DEPTH));
    wire text_disp = ctrl_q.disp_stat[map_video_pkg::STAT_TEXT_ACT];
    // display mode shuts the CPU out of the page
    wire page_wr = wr_fire & page_hit & ~text_disp;

    wire wr_bus = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_BUS_SEL);
    wire wr_m1 = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_MON1_DIG);
    wire wr_m2 = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_MON2_DIG);
    wire wr_map = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_MAP_DISP);
    wire wr_stat = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_DISP_STAT);
    wire wr_ext = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_EXT_VID);
    wire wr_mode = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_MODE_STAT);
    wire wr_tim = wr_fire & hit(wb_adr_i, map_video_pkg::OFF_TIMING);

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_bus) begin
            ctrl_d.bus_sel = wb_byte[4:0];
        end
        if (wr_m1) begin
            ctrl_d.mon1_dig = wb_byte[5:0];
        end
        if (wr_m2) begin
            ctrl_d.mon2_dig = wb_byte[5:0];
        end
        if (wr_map) begin
            ctrl_d.map_disp = wb_byte[5:0];
        end
        if (wr_stat) begin
            ctrl_d.disp_stat = wb_byte[2:0];
        end
        if (wr_ext) begin
            ctrl_d.ext_vid = wb_byte;
        end
        if (wr_tim) begin
            ctrl_d.hires = wb_byte[map_video_pkg::TIMING_HIRES_BIT];
        end
    end

    // host request: pin passes two flops; a new edge beats a clear
    wire mreq_rise = mreq_s2_q & ~mreq_s3_q;
    wire mclr = wr_mode & wb_byte[map_video_pkg::MODE_FLAG_BIT];
    wire mflag_d = mreq_rise | (mflag_q & ~mclr);

    logic field_q, blank_q;
    wire [31:0] rd_mux =
        hit(wb_adr_i, map_video_pkg::OFF_BUS_SEL) ? {27'h0, ctrl_q.bus_sel} :
        hit(wb_adr_i, map_video_pkg::OFF_MON1_DIG) ? {26'h0, ctrl_q.mon1_dig} :
        hit(wb_adr_i, map_video_pkg::OFF_MON2_DIG) ? {26'h0, ctrl_q.mon2_dig} :
        hit(wb_adr_i, map_video_pkg::OFF_MAP_DISP) ? {26'h0, ctrl_q.map_disp} :
        hit(wb_adr_i, map_video_pkg::OFF_DISP_STAT) ? {29'h0, ctrl_q.disp_stat} :
        hit(wb_adr_i, map_video_pkg::OFF_EXT_VID) ? {24'h0, ctrl_q.ext_vid} :
        hit(wb_adr_i, map_video_pkg::OFF_MODE_STAT) ?
            {28'h0, blank_q, field_q, mreq_s2_q, mflag_q} :
        hit(wb_adr_i, map_video_pkg::OFF_TIMING) ? {31'h0, ctrl_q.hires} :
        32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= map_video_pkg::CTRL_RESET;
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            mreq_s1_q <= 1'b0;
            mreq_s2_q <= 1'b0;
            mreq_s3_q <= 1'b0;
            mflag_q <= 1'b0;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                rdat_q <= rd_mux;
            end
            mreq_s1_q <= mode_request_i;
            mreq_s2_q <= mreq_s1_q;
            mreq_s3_q <= mreq_s2_q;
            mflag_q <= mflag_d;
        end
    end

    // ****************************************************************
    // raster timing
    // ****************************************************************
    logic [9:0] px_q, line_q;
    wire line_end = px_q == 10'(H_TOTAL - 1);
    wire last_line = line_q == 10'(V_TOTAL - 1);
    wire frame_end = line_end & last_line;
    wire vis = (px_q < 10'(H_ACTIVE)) & (line_q < 10'(V_ACTIVE));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            px_q <= 10'h0;
            line_q <= 10'h0;
            field_q <= 1'b0;
            blank_q <= 1'b1;
        end else if (ce_i) begin
            px_q <= line_end ? 10'h0 : px_q + 10'h1;
            if (line_end) begin
                line_q <= last_line ? 10'h0 : line_q + 10'h1;
            end
            if (frame_end) begin
                field_q <= ctrl_q.hires & ~field_q;
            end
            blank_q <= ~vis;
        end
    end

    // ****************************************************************
    // word fetch and serialisers
    // ****************************************************************
    // slots 0..4 of each word fetch the next word of memories 1..5
    wire [4:0] slot = px_q[4:0];
    wire [4:0] wi = px_q[9:5];
    wire last_word = wi == 5'((H_TOTAL / map_video_pkg::WORD_W) - 1);
    wire [4:0] next_wi = last_word ? 5'h0 : wi + 5'h1;
    wire [9:0] next_line = !last_word ? line_q : (last_line ? 10'h0 : line_q + 10'h1);
    wire fetch_go = slot < 5'(map_video_pkg::NUM_MEMS);
    // memories parked on the input bus are never read here; no host path exists
    // next bus select, so a strobe never meets a memory parked on this very edge
    wire [4:0] rd_d = fetch_go ? ((5'h01 << slot[2:0]) & ~ctrl_d.bus_sel) : 5'h0;
    wire [15:0] addr_d = {1'b0, field_q & ctrl_q.hires, next_line[8:0], next_wi};
    wire load = slot == 5'h1f;

    logic [4:0] rd_q, rd_seen_q;
    logic [15:0] addr_q;
    logic [31:0] stage_q [map_video_pkg::NUM_MEMS];
    logic [31:0] shift_q [map_video_pkg::NUM_MEMS];
    logic [4:0] ser;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= 5'h0;
            rd_seen_q <= 5'h0;
            addr_q <= 16'h0;
        end else if (ce_i) begin
            rd_q <= rd_d;
            rd_seen_q <= rd_q;
            addr_q <= addr_d;
        end
    end

    genvar k;
    generate
        for (k = 0; k < map_video_pkg::NUM_MEMS; k++) begin : g_plane
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    stage_q[k] <= 32'h0;
                    shift_q[k] <= 32'h0;
                end else if (ce_i) begin
                    if (rd_seen_q[k]) begin
                        stage_q[k] <= display_data_bus_i;
                    end
                    if (load) begin
                        shift_q[k] <= ctrl_q.bus_sel[k] ? 32'h0 : stage_q[k];
                    end else begin
                        shift_q[k] <= {shift_q[k][30:0], 1'b0};
                    end
                end
            end
            assign ser[k] = shift_q[k][31];
        end
    endgenerate

    // ****************************************************************
    // shade mapper and monitor selection
    // ****************************************************************
    // least significant map plane lives in memory 2
    wire [3:0] grey_level = {ser[3], ser[2], ser[0], ser[1]};
    wire [3:0] fmt = ctrl_q.map_disp[3:0];

    function automatic logic [3:0] shade(input logic [3:0] f, input logic [3:0] g);
        logic [3:0] d;
        d = g - f;
        if (f == map_video_pkg::MAP_EIGHT) begin
            shade = {g[3:1], 1'b0};
        end else if (f > map_video_pkg::SLIDE_MAX) begin
            shade = g;
        end else if (g < f) begin
            shade = 4'h0;
        end else if (d > map_video_pkg::SLIDE_SPAN) begin
            shade = map_video_pkg::SLIDE_TOP;
        end else begin
            shade = {d[2:0], 1'b0};
        end
    endfunction : shade

    wire show_map = ctrl_q.disp_stat[map_video_pkg::STAT_SHOW_MAP];
    wire [3:0] shade_d = (show_map & vis) ? shade(fmt, grey_level) : 4'h0;
    wire inset1_d = vis & |(ser & ctrl_q.mon1_dig[4:0]);
    wire inset2_d = vis & |(ser & ctrl_q.mon2_dig[4:0]);

    // ****************************************************************
    // text page memory
    // ****************************************************************
    logic [7:0] page_mem [map_video_pkg::PAGE_DEPTH];
    logic [10:0] row_base_q;
    logic [4:0] row_q;
    logic [3:0] cline_q;
    wire [6:0] col = px_q[9:3];
    wire [10:0] taddr = row_base_q + {4'h0, col};
    wire t_in = (col < 7'(map_video_pkg::TEXT_COLS))
        & (row_q < 5'(map_video_pkg::TEXT_ROWS));
    wire row_end = cline_q == 4'(CHAR_H - 1);

    always_ff @(posedge clk_i) begin
        if (ce_i && page_wr) begin
            page_mem[page_idx] <= wb_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_base_q <= 11'h0;
            row_q <= 5'h0;
            cline_q <= 4'h0;
        end else if (ce_i) begin
            if (frame_end) begin
                row_base_q <= 11'h0;
                row_q <= 5'h0;
                cline_q <= 4'h0;
            end else if (line_end) begin
                cline_q <= row_end ? 4'h0 : cline_q + 4'h1;
                if (row_end) begin
                    row_q <= row_q + 5'h1;
                    row_base_q <= row_base_q + 11'(map_video_pkg::TEXT_COLS);
                end
            end
        end
    end

    // ****************************************************************
    // output flops
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mapped_shade_out_o <= 4'h0;
            mon_one_inset_data_o <= 1'b0;
            mon_two_inset_data_o <= 1'b0;
            text_char_o <= 8'h0;
        end else if (ce_i) begin
            mapped_shade_out_o <= shade_d;
            mon_one_inset_data_o <= inset1_d;
            mon_two_inset_data_o <= inset2_d;
            text_char_o <= (text_disp & t_in) ? page_mem[taddr] : 8'h0;
        end
    end

    // control fields are flops already; these are plain renames
    assign bus_select_o = ctrl_q.bus_sel;
    assign mem_read_o = rd_q;
    assign display_addr_bus_o = addr_q;
    assign mon_one_text_enable_o = ctrl_q.mon1_dig[map_video_pkg::DIG_TEXT_BIT];
    assign mon_two_text_enable_o = ctrl_q.mon2_dig[map_video_pkg::DIG_TEXT_BIT];
    assign mon_one_map_enable_o = ctrl_q.map_disp[map_video_pkg::MAP_MON1_BIT];
    assign mon_two_map_enable_o = ctrl_q.map_disp[map_video_pkg::MAP_MON2_BIT];
    assign show_map_o = show_map;
    assign text_activate_o = text_disp;
    assign inset_white_select_o = ctrl_q.disp_stat[map_video_pkg::STAT_INSET_WHITE];
    assign mon_one_ext_select_o = ctrl_q.ext_vid[3:0];
    assign mon_two_ext_select_o = ctrl_q.ext_vid[7:4];
    assign blank_o = blank_q;
    assign field_o = field_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single_pulse: assert property (ack_q && ce_i |=> !ack_q)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (req && !ack_q && ce_i |=> ack_q)
        else $error("request not acknowledged next cycle");
    a_input_bus_quiet: assert property ((rd_q & ctrl_q.bus_sel) == 5'h0)
        else $error("memory on input bus was read");
    a_read_one_hot: assert property ($onehot0(rd_q))
        else $error("more than one memory read at once");
    a_map_gate_off: assert property (ce_i && !(show_map && vis)
        |=> mapped_shade_out_o == 4'h0)
        else $error("map shown while blanked or off");
    a_eight_drops_lsb: assert property (ce_i && fmt == map_video_pkg::MAP_EIGHT
        |=> !mapped_shade_out_o[0])
        else $error("8-level map kept its low plane");
    a_inset_masked: assert property (ce_i && ctrl_q.mon1_dig[4:0] == 5'h0
        |=> !mon_one_inset_data_o)
        else $error("inset shown with no memory chosen");
    a_mode_flag_set: assert property (ce_i && mreq_rise |=> mflag_q)
        else $error("mode request edge lost");
    a_field_low_res: assert property (!ctrl_q.hires && !$past(ctrl_q.hires)
        && ce_i |=> !addr_q[14])
        else $error("field index used outside 512 mode");

endmodule : map_video_display_pipeline

// ---- testbench/display_mem_model.sv ----
`timescale 1ns/1ps
module display_mem_model (
    // clock
    input wire logic clk_i,
    // display bus controller side
    input wire logic [4:0] mem_read_i,
    input wire logic [4:0] bus_select_i,
    input wire logic [15:0] addr_i,
    output logic [31:0] data_o,
    // bench side: plane content per memory, sticky misuse flag
    input wire logic [4:0] planes_i,
    output logic bad_strobe_o
);
    // ****************************************************************
    // five plane memories on the display bus
    // ****************************************************************
    logic [31:0] data_q = 32'h0000_0000;
    logic bad_q = 1'b0;
    wire logic hit = |(mem_read_i & ~bus_select_i);
    wire logic [4:0] lit = mem_read_i & planes_i;
    wire logic [15:0] unused_addr = addr_i;

    // every word of a memory holds its plane value; the bus flips when released
    // so a capture in the wrong cycle cannot look right
    always_ff @(posedge clk_i) begin
        data_q <= hit ? {32{|lit}} : ~data_q;
        if (|(mem_read_i & bus_select_i)) begin
            bad_q <= 1'b1;
        end
    end

    assign data_o = data_q;
    assign bad_strobe_o = bad_q;
endmodule : display_mem_model

// ---- testbench/tb_map_video_display_pipeline.sv ----
`timescale 1ns/1ps
module tb_map_video_display_pipeline;
    logic clk_i, rst_i, mode_request_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [13:0] wb_adr_i;
    logic [3:0] wb_sel_i, mapped_shade_out_o, mon_one_ext_select_o, mon_two_ext_select_o;
    logic [31:0] wb_dat_i, wb_dat_o, display_data_bus_i, rd;
    logic [4:0] bus_select_o, mem_read_o, planes;
    logic [15:0] display_addr_bus_o;
    logic [7:0] text_char_o;
    logic mon_one_inset_data_o, mon_two_inset_data_o, mon_one_text_enable_o;
    logic mon_two_text_enable_o, mon_one_map_enable_o, mon_two_map_enable_o;
    logic show_map_o, text_activate_o, inset_white_select_o, blank_o, field_o, bad_strobe;
    logic ce = 1'b1;
    logic [1:0] seen;
    logic [16:0] snap;
    int num_errors = 0;
    int cmp_count = 0;
    logic [13:0] offs [6];
    logic [7:0] vals [6];
    logic [19:0] outs [6];
    wire logic [19:0] ctl = {bus_select_o, mon_one_text_enable_o, mon_two_text_enable_o,
        mon_one_map_enable_o, mon_two_map_enable_o, show_map_o, text_activate_o,
        inset_white_select_o, mon_one_ext_select_o, mon_two_ext_select_o};

    map_video_display_pipeline #(.H_TOTAL(64), .H_ACTIVE(32), .V_TOTAL(4), .V_ACTIVE(2),
        .CHAR_H(2)) map_video_display_pipeline_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_request_i(mode_request_i),
        .bus_select_o(bus_select_o), .mem_read_o(mem_read_o),
        .display_addr_bus_o(display_addr_bus_o), .display_data_bus_i(display_data_bus_i),
        .mon_one_inset_data_o(mon_one_inset_data_o), .mon_two_inset_data_o(mon_two_inset_data_o),
        .mon_one_text_enable_o(mon_one_text_enable_o),
        .mon_two_text_enable_o(mon_two_text_enable_o),
        .mon_one_map_enable_o(mon_one_map_enable_o), .mon_two_map_enable_o(mon_two_map_enable_o),
        .mapped_shade_out_o(mapped_shade_out_o), .show_map_o(show_map_o),
        .text_activate_o(text_activate_o), .inset_white_select_o(inset_white_select_o),
        .mon_one_ext_select_o(mon_one_ext_select_o), .mon_two_ext_select_o(mon_two_ext_select_o),
        .blank_o(blank_o), .field_o(field_o), .text_char_o(text_char_o));

    display_mem_model display_mem_model_inst (.clk_i(clk_i), .mem_read_i(mem_read_o),
        .bus_select_i(bus_select_o), .addr_i(display_addr_bus_o), .data_o(display_data_bus_i),
        .planes_i(planes), .bad_strobe_o(bad_strobe));

    // ****************************************************************
    // bus and compare helpers
    // ****************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wb_xfer(input logic we, input logic [13:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) check(32'h1, 32'h0, "ack missing");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer

    task automatic wb_read_check(input logic [13:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0);
        check(rd, exp, "register read");
    endtask : wb_read_check

    // settle a few pixels into the visible part of a line (lvl 1) or into its blanked part (lvl 0)
    task automatic wait_active(input logic lvl);
        int n;
        n = 0;
        while (blank_o !== lvl && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        while (blank_o !== !lvl && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        repeat (12) @(posedge clk_i);
        #1;
    endtask : wait_active

    function automatic logic [3:0] map_expect(input logic [3:0] code, input logic [3:0] g);
        if (code == 4'he) return {g[3:1], 1'b0};
        if (code > 4'h8) return g;
        if (g < code) return 4'h0;
        if (g > code + 4'h7) return 4'he;
        return 4'((g - code) << 1);
    endfunction : map_expect

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        repeat (40000) @(posedge clk_i);
        num_errors++;
        stop_test();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        {rst_i, mode_request_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
        wb_adr_i = 14'h0000;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0000_0000;
        planes = 5'h0b;
        offs = '{map_video_pkg::OFF_BUS_SEL, map_video_pkg::OFF_MON1_DIG,
            map_video_pkg::OFF_MON2_DIG, map_video_pkg::OFF_MAP_DISP,
            map_video_pkg::OFF_DISP_STAT, map_video_pkg::OFF_EXT_VID};
        vals = '{8'h15, 8'h20, 8'h20, 8'h30, 8'h07, 8'ha5};
        outs = '{20'ha8000, 20'h04000, 20'h02000, 20'h01800, 20'h00700, 20'h0005a};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check(32'(ctl), 32'h0, "outputs after reset");
        for (int i = 0; i < 6; i++) wb_read_check(offs[i], 32'h0);
        $display("test reset done");

        // upper byte lanes are ignored, each field lands on its own pins
        for (int i = 0; i < 6; i++) begin
            wb_xfer(1'b1, offs[i], {24'hffffff, vals[i]});
            repeat (2) @(posedge clk_i);
            #1;
            check(32'(ctl), 32'(outs[i]), "control pins");
            wb_read_check(offs[i], 32'(vals[i]));
            wb_xfer(1'b1, offs[i], 32'h0);
        end
        ce <= 1'b0;
        #1;
        snap = {blank_o, display_addr_bus_o};
        repeat (40) @(posedge clk_i);
        ce <= 1'b1;
        #1;
        check(32'({blank_o, display_addr_bus_o}), 32'(snap), "enable low hold");
        wb_xfer(1'b1, 14'h0020, 32'h0000_00ff);
        wb_read_check(14'h0020, 32'h0);
        wb_sel_i <= 4'he;
        wb_xfer(1'b1, map_video_pkg::OFF_EXT_VID, 32'h0000_00ff);
        wb_sel_i <= 4'hf;
        wb_read_check(map_video_pkg::OFF_EXT_VID, 32'h0);
        $display("test registers done");

        mode_request_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb_xfer(1'b0, map_video_pkg::OFF_MODE_STAT, 32'h0);
        check(32'(rd[1:0]), 32'h3, "mode request flag");
        mode_request_i <= 1'b0;
        wb_xfer(1'b1, map_video_pkg::OFF_MODE_STAT, 32'h1);
        wb_xfer(1'b0, map_video_pkg::OFF_MODE_STAT, 32'h0);
        check(32'(rd[0]), 32'h0, "mode flag cleared");
        wb_xfer(1'b1, map_video_pkg::OFF_TIMING, 32'h1);
        for (int n = 0; n < 300 && field_o !== 1'b1; n++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        #1;
        check(32'({field_o, display_addr_bus_o[14]}), 32'h3, "field index");
        wb_xfer(1'b1, map_video_pkg::OFF_TIMING, 32'h0);
        wb_xfer(1'b1, map_video_pkg::OFF_PAGE_BASE, 32'h5a);
        wb_xfer(1'b1, map_video_pkg::OFF_DISP_STAT, 32'h2);
        wb_xfer(1'b1, map_video_pkg::OFF_PAGE_BASE, 32'h33);
        seen = 2'h0;
        repeat (300) @(posedge clk_i) seen |= {text_char_o === 8'h5a, text_char_o === 8'h33};
        check(32'(seen), 32'h2, "text page");
        $display("test mode request done");

        // grey 11 with planes {mem4,mem3,mem1,mem2} = 1,0,1,1
        wb_xfer(1'b1, map_video_pkg::OFF_DISP_STAT, 32'h1);
        repeat (600) @(posedge clk_i);
        for (int c = 0; c < 16; c++) begin
            wb_xfer(1'b1, map_video_pkg::OFF_MAP_DISP, 32'(c));
            wait_active(1'b1);
            check(32'(mapped_shade_out_o), 32'(map_expect(4'(c), 4'hb)), "shade");
        end
        wait_active(1'b0);
        check(32'(mapped_shade_out_o), 32'h0, "shade while blanked");
        wb_xfer(1'b1, map_video_pkg::OFF_DISP_STAT, 32'h0);
        wait_active(1'b1);
        check(32'(mapped_shade_out_o), 32'h0, "shade with map off");
        planes <= 5'h03;
        wb_xfer(1'b1, map_video_pkg::OFF_DISP_STAT, 32'h1);
        wb_xfer(1'b1, map_video_pkg::OFF_MAP_DISP, 32'h8);
        repeat (600) @(posedge clk_i);
        wait_active(1'b1);
        check(32'(mapped_shade_out_o), 32'h0, "shade below slide base");
        $display("test mapper done");

        planes <= 5'h0b;
        wb_xfer(1'b1, map_video_pkg::OFF_MON1_DIG, 32'h01);
        wb_xfer(1'b1, map_video_pkg::OFF_MON2_DIG, 32'h10);
        repeat (600) @(posedge clk_i);
        wait_active(1'b1);
        check(32'({mon_one_inset_data_o, mon_two_inset_data_o}), 32'h2, "inset");
        wb_xfer(1'b1, map_video_pkg::OFF_MON2_DIG, 32'h03);
        wait_active(1'b1);
        check(32'(mon_two_inset_data_o), 32'h1, "inset two");
        // memory 2 taken to the input bus: its plane reads as zero
        wb_xfer(1'b1, map_video_pkg::OFF_MAP_DISP, 32'hf);
        wb_xfer(1'b1, map_video_pkg::OFF_BUS_SEL, 32'h02);
        repeat (600) @(posedge clk_i);
        wait_active(1'b1);
        check(32'(mapped_shade_out_o), 32'ha, "shade without memory 2");
        check(32'(bad_strobe), 32'h0, "strobe to input-bus memory");
        $display("test inset and bus select done");
        stop_test();
    end
endmodule : tb_map_video_display_pipeline
